/* hdl/nvmem_two_wire_slave.sv */
// Two-wire slave front end and 512 x 8 array of the nonvolatile memory.
//
// Overview of operation
// - Read data and acknowledge change on clock fall; incoming bits sampled on clock rise.
// - Write-protect high blocks every array write; low lets every location be written.
// - Respond only when the address select field equals the two strap pins.
// - A floating write-protect pin reads low, so writes stay enabled.
// - The array holds 512 bytes, each reached by a unique 9-bit address.
// - Address is one page bit above an eight-bit word address.
// - Array writes finish within the bus cycle; no ready polling is ever needed.
// - A received byte is written to the array right after its last bit.
// - Data rising while clock is high is a stop.
// - A stop abandons whatever operation is still pending.
// - Data falling while clock is high is a start.
// - A start at any time aborts and waits for a new slave address.
// - Power-on reset puts the interface into idle.
// - The data pin is only pulled low or released, never driven high.
// - Address bits 3 and 2 match straps, bit 1 is page, bit 0 read.
// - The receiver acknowledges each byte but protected data in the ninth clock; no acknowledge ends it.
// - The address latch increments after each written or read data byte, before acknowledge, wrapping to zero.
// - Under write protect, data bytes get no acknowledge and no address advance.
`timescale 1ns/1ps

module nvmem_two_wire_slave #(
    parameter logic [3:0] DEV_TYPE = nvmem_pkg::DEV_TYPE_DEFAULT // Value is arbitrary.
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic serial_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] device_select_straps,
    input wire logic write_protect
);

    // Control clock domain: start and stop detection from the pins.
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    logic start_hold_reg, start_hold_next;
    logic stop_hold_reg, stop_hold_next;
    logic sda_out_reg;

    wire scl_high_steady = scl_sync_reg && scl_prev_reg;
    wire sda_fell = sda_prev_reg && !sda_sync_reg;
    wire sda_rose = !sda_prev_reg && sda_sync_reg;
    wire start_seen = scl_high_steady && sda_fell;
    wire stop_seen = scl_high_steady && sda_rose;

    // The hold levels stay up until the clock falls, so the link logic is held
    // clear across the whole condition and released well before the next rise.
    assign start_hold_next = start_seen || (start_hold_reg && scl_sync_reg);
    // A start close behind a stop, clock still high, must end the stop's hold;
    // otherwise the new frame would be cleared and disarmed as it opens.
    assign stop_hold_next = stop_seen
        || (stop_hold_reg && scl_sync_reg && !start_seen);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            start_hold_reg <= 1'b0;
            stop_hold_reg <= 1'b0;
            sda_out_reg <= 1'b0;
        end else begin
            scl_meta_reg <= serial_clk;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
            start_hold_reg <= start_hold_next;
            stop_hold_reg <= stop_hold_next;
            sda_out_reg <= 1'b0;
        end
    end

    assign sda_out = sda_out_reg;

    // Asynchronous clears into the link domain come straight from flip-flops.
    wire link_clr = !reset_n || start_hold_reg || stop_hold_reg;

    // Link clock domain.
    nvmem_pkg::link_state_e state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg;
    logic rd_mode_reg;
    logic armed_reg;
    logic [nvmem_pkg::ADDR_W-1:0] addr_reg;
    nvmem_pkg::pin_set_s pin_meta_reg, pin_sync_reg;
    logic sda_oe_reg, sda_oe_next;
    logic [nvmem_pkg::WORD_W-1:0] mem [nvmem_pkg::DEPTH];

    // Straps and protect are static pins; a floating protect pin is pulled low
    // at the pad, and the synchroniser also comes out of reset low.
    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= nvmem_pkg::PIN_RESET;
            pin_sync_reg <= nvmem_pkg::PIN_RESET;
        end else begin
            pin_meta_reg <= {write_protect, device_select_straps};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire wp_on = pin_sync_reg.write_protect;
    wire [7:0] rx_byte = {shift_reg[6:0], sda_in};
    nvmem_pkg::slave_addr_s rx_addr;
    assign rx_addr = rx_byte;
    wire byte_end = (cnt_reg == nvmem_pkg::BIT_LAST);
    wire type_hit = (rx_addr.dev_type == DEV_TYPE);
    wire sel_hit = (rx_addr.sel_high == pin_sync_reg.straps[1])
        && (rx_addr.sel_low == pin_sync_reg.straps[0]);
    wire addr_hit = type_hit && sel_hit;
    wire in_addr = armed_reg && (state_reg == nvmem_pkg::S_ADDR);
    wire page_load = in_addr && byte_end && addr_hit;
    wire word_load = armed_reg && (state_reg == nvmem_pkg::S_WORD) && byte_end;
    wire wdata_end = armed_reg && (state_reg == nvmem_pkg::S_WDATA) && byte_end;
    wire wr_commit = wdata_end && !wp_on;
    wire rd_done = armed_reg && (state_reg == nvmem_pkg::S_RDATA) && byte_end;
    wire addr_step = wr_commit || rd_done;
    wire [nvmem_pkg::ADDR_W-1:0] addr_inc = addr_reg + nvmem_pkg::ADDR_STEP;
    wire [7:0] rd_data = mem[addr_reg];
    wire rd_bit = rd_data[~cnt_reg];
    wire in_data = (state_reg == nvmem_pkg::S_ADDR) || (state_reg == nvmem_pkg::S_WORD)
        || (state_reg == nvmem_pkg::S_WDATA) || (state_reg == nvmem_pkg::S_RDATA);
    wire ack_drive = (state_reg == nvmem_pkg::S_ADDR_ACK)
        || (state_reg == nvmem_pkg::S_WORD_ACK) || (state_reg == nvmem_pkg::S_WDATA_ACK);

    assign cnt_next = in_data ? cnt_reg + 3'h1 : nvmem_pkg::BIT_FIRST;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            nvmem_pkg::S_ADDR: begin
                if (byte_end) begin
                    state_next = addr_hit ? nvmem_pkg::S_ADDR_ACK : nvmem_pkg::S_IGNORE;
                end
            end
            nvmem_pkg::S_ADDR_ACK: begin
                state_next = rd_mode_reg ? nvmem_pkg::S_RDATA : nvmem_pkg::S_WORD;
            end
            nvmem_pkg::S_WORD: begin
                if (byte_end) begin
                    state_next = nvmem_pkg::S_WORD_ACK;
                end
            end
            nvmem_pkg::S_WORD_ACK: begin
                state_next = nvmem_pkg::S_WDATA;
            end
            nvmem_pkg::S_WDATA: begin
                if (byte_end) begin
                    // Protected data is left without acknowledge.
                    state_next = wp_on ? nvmem_pkg::S_IGNORE : nvmem_pkg::S_WDATA_ACK;
                end
            end
            nvmem_pkg::S_WDATA_ACK: begin
                state_next = nvmem_pkg::S_WDATA;
            end
            nvmem_pkg::S_RDATA: begin
                if (byte_end) begin
                    state_next = nvmem_pkg::S_RDATA_ACK;
                end
            end
            nvmem_pkg::S_RDATA_ACK: begin
                // A released line in the ninth clock ends the read.
                state_next = sda_in ? nvmem_pkg::S_IGNORE : nvmem_pkg::S_RDATA;
            end
            nvmem_pkg::S_IGNORE: begin
                state_next = nvmem_pkg::S_IGNORE;
            end
        endcase
    end

    // Any start or stop clears the engine back to waiting for an address.
    always_ff @(posedge serial_clk or posedge link_clr) begin
        if (link_clr) begin
            state_reg <= nvmem_pkg::S_ADDR;
            cnt_reg <= nvmem_pkg::BIT_FIRST;
            shift_reg <= nvmem_pkg::BYTE_RESET;
            rd_mode_reg <= 1'b0;
        end else if (armed_reg) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            shift_reg <= rx_byte;
            rd_mode_reg <= page_load ? rx_addr.rd_not_wr : rd_mode_reg;
        end
    end

    // Only a start arms the engine; a stop disarms it until the next start.
    // The flag lives in the control domain and only moves while a hold level
    // keeps the link logic cleared, so it is settled before the next clock rise.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            armed_reg <= 1'b0;
        end else if (stop_seen) begin
            armed_reg <= 1'b0;
        end else if (start_seen) begin
            armed_reg <= 1'b1;
        end
    end

    // The address latch survives start and stop, so reads continue from it.
    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= nvmem_pkg::ADDR_RESET;
        end else if (page_load) begin
            addr_reg <= {rx_addr.page, addr_reg[7:0]};
        end else if (word_load) begin
            addr_reg <= {addr_reg[8], rx_byte};
        end else if (addr_step) begin
            addr_reg <= addr_inc;
        end
    end

    // The write lands on the edge that completes the byte, so it is done before
    // the acknowledge and the master never has to poll.
    always_ff @(posedge serial_clk) begin
        if (wr_commit) begin
            mem[addr_reg] <= rx_byte;
        end
    end

    assign sda_oe_next = armed_reg && (ack_drive
        || ((state_reg == nvmem_pkg::S_RDATA) && !rd_bit));

    always_ff @(negedge serial_clk or posedge link_clr) begin
        if (link_clr) begin
            sda_oe_reg <= 1'b0;
        end else begin
            sda_oe_reg <= sda_oe_next;
        end
    end

    assign sda_oe = sda_oe_reg;

    a_start_detect: assert property (@(posedge mclk) disable iff (!reset_n)
        start_seen |=> start_hold_reg)
        else $error("start condition not held");

    a_stop_detect: assert property (@(posedge mclk) disable iff (!reset_n)
        stop_seen |=> stop_hold_reg)
        else $error("stop condition not held");

    a_start_abort: assert property (@(posedge mclk) disable iff (!reset_n)
        (start_hold_reg && !stop_seen && !stop_hold_reg)
            |=> (state_reg == nvmem_pkg::S_ADDR) && !sda_oe_reg && armed_reg)
        else $error("start did not return to address wait");

    a_stop_abandon: assert property (@(posedge mclk) disable iff (!reset_n)
        (stop_hold_reg && !start_seen) |=> !armed_reg && !sda_oe_reg)
        else $error("stop did not abandon operation");

    // The synchronised clock lags the pin, so the raw clock is watched here:
    // high at both of the last two edges means no fall lay between them.
    a_oe_on_fall: assert property (@(posedge mclk)
        disable iff (!reset_n || start_hold_reg || stop_hold_reg)
        (serial_clk && $past(serial_clk)) |-> $stable(sda_oe_reg))
        else $error("data output moved while clock high");

    a_select_miss: assert property (@(posedge serial_clk) disable iff (link_clr)
        (in_addr && byte_end && !sel_hit) |=> state_reg == nvmem_pkg::S_IGNORE)
        else $error("unselected address not ignored");

    a_protect_noack: assert property (@(posedge serial_clk) disable iff (link_clr)
        (wdata_end && wp_on) |=> (state_reg == nvmem_pkg::S_IGNORE) && $stable(addr_reg))
        else $error("protected byte acknowledged or counted");

    a_addr_wrap: assert property (@(posedge serial_clk) disable iff (link_clr)
        addr_step |=> addr_reg == $past(addr_inc))
        else $error("address latch did not advance");

    a_ack_driven: assert property (@(posedge serial_clk) disable iff (link_clr)
        (armed_reg && ack_drive) |-> sda_oe_reg)
        else $error("acknowledge not driven in ninth clock");

    a_open_drain: assert property (@(posedge mclk) disable iff (!reset_n)
        sda_oe |-> !sda_out)
        else $error("data pin driven high");

    // The checks below, all but the last, run on the serial clock; a start or stop clears the
    // link logic asynchronously, so they stay quiet while that clear stands.
    a_type_miss: assert property (@(posedge serial_clk) disable iff (link_clr)
        (in_addr && byte_end && !type_hit) |=> state_reg == nvmem_pkg::S_IGNORE)
        else $error("foreign device type not ignored");

    a_ignore_quiet: assert property (@(posedge serial_clk) disable iff (link_clr)
        (state_reg == nvmem_pkg::S_IGNORE) |-> !sda_oe_reg)
        else $error("data line pulled while ignoring");

    a_page_select: assert property (@(posedge serial_clk) disable iff (link_clr)
        page_load |=> addr_reg[nvmem_pkg::ADDR_W-1] == $past(rx_addr.page))
        else $error("page bit not latched");

    a_word_load: assert property (@(posedge serial_clk) disable iff (link_clr)
        word_load |=> addr_reg[7:0] == $past(rx_byte))
        else $error("word address not latched");

    a_rw_decode: assert property (@(posedge serial_clk) disable iff (link_clr)
        page_load |=> rd_mode_reg == $past(rx_addr.rd_not_wr))
        else $error("read or write bit not latched");

    a_word_ack: assert property (@(posedge serial_clk) disable iff (link_clr)
        word_load |=> state_reg == nvmem_pkg::S_WORD_ACK)
        else $error("word address not acknowledged");

    a_cnt_wrap: assert property (@(posedge serial_clk) disable iff (link_clr)
        (armed_reg && in_data && byte_end) |=> cnt_reg == nvmem_pkg::BIT_FIRST)
        else $error("bit counter did not restart after a byte");

    a_rx_release: assert property (@(posedge serial_clk) disable iff (link_clr)
        (armed_reg && in_data && (state_reg != nvmem_pkg::S_RDATA)) |-> !sda_oe_reg)
        else $error("data line pulled while receiving");

    // A read bit is a released line for a one and a pull for a zero.
    a_read_bit: assert property (@(posedge serial_clk) disable iff (link_clr)
        (armed_reg && state_reg == nvmem_pkg::S_RDATA) |-> sda_oe_reg != rd_bit)
        else $error("read bit not on the data line");

    a_read_release: assert property (@(posedge serial_clk) disable iff (link_clr)
        (armed_reg && state_reg == nvmem_pkg::S_RDATA_ACK) |-> !sda_oe_reg)
        else $error("data line held in read acknowledge clock");

    a_commit_ack: assert property (@(posedge serial_clk) disable iff (link_clr)
        wr_commit |=> state_reg == nvmem_pkg::S_WDATA_ACK)
        else $error("written byte not acknowledged at once");

    // A protected write must leave the array untouched as well as unacknowledged.
    a_protect_block: assert property (@(posedge serial_clk) disable iff (link_clr)
        wp_on |-> !wr_commit)
        else $error("array written under write protect");

    a_hold_release: assert property (@(posedge mclk) disable iff (!reset_n)
        !scl_sync_reg |=> !start_hold_reg && !stop_hold_reg)
        else $error("hold level outlived the clock high phase");

endmodule // nvmem_two_wire_slave

/* inc/nvmem_pkg.sv */
// Package with constants and types for the two-wire memory slave.
package nvmem_pkg;

    localparam int ADDR_W = 9;
    localparam int WORD_W = 8;
    localparam int DEPTH = 512;
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h6;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 9'h000;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 9'h001;
    localparam logic [WORD_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [1:0] STRAP_RESET = 2'h0;
    localparam logic [2:0] PIN_RESET = 3'h0;

    typedef struct packed {
        logic [3:0] dev_type;
        logic sel_high;
        logic sel_low;
        logic page;
        logic rd_not_wr;
    } slave_addr_s;

    typedef struct packed {
        logic write_protect;
        logic [1:0] straps;
    } pin_set_s;

    typedef enum logic [8:0] {
        S_ADDR = 9'h001,
        S_ADDR_ACK = 9'h002,
        S_WORD = 9'h004,
        S_WORD_ACK = 9'h008,
        S_WDATA = 9'h010,
        S_WDATA_ACK = 9'h020,
        S_RDATA = 9'h040,
        S_RDATA_ACK = 9'h080,
        S_IGNORE = 9'h100
    } link_state_e;

endpackage

/* tb/serial_nv_memory_two_wire_slave_bench.sv */
// Self-checking bench for the two-wire memory slave with random data and addresses.
`timescale 1ns/1ps

module serial_nv_memory_two_wire_slave_bench;
    localparam logic [3:0] DEV = 4'h5; // Value is arbitrary.
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] straps = 2'h0;
    logic wp = 1'b0; // Pad pull-down modelled as a low, raised only for the protected write.
    logic serial_clk;
    logic sda_drive;
    logic sda_out;
    logic sda_oe;
    wire logic sda_in = sda_drive & ~sda_oe;
    int err_count = 0;
    int checks = 0;
    logic [7:0] mem [0:511];
    logic [8:0] lat = 9'h000;
    logic [8:0] p_word;
    logic [7:0] rx;
    logic ack;

    always #2.5 mclk = ~mclk;

    nvmem_two_wire_slave #(.DEV_TYPE(DEV)) dut (.mclk(mclk), .reset_n(reset_n),
        .serial_clk(serial_clk), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .device_select_straps(straps), .write_protect(wp));
    two_wire_master m (.serial_clk(serial_clk), .sda_drive(sda_drive), .sda_wire(sda_in));

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // The latch wraps from the last location to zero by plain 9-bit overflow.
    function automatic logic [8:0] next_addr(input logic [8:0] a);
        return a + 9'h001;
    endfunction

    task automatic send_addr(input logic [3:0] ty, input logic [1:0] sel, input logic pg,
        input logic rd_bit, input logic exp_ack);
        m.start_cond();
        m.xfer({ty, sel, pg, rd_bit}, 8, 1'b1, rx, ack);
        check({8'h00, ack}, {8'h00, ~exp_ack});
    endtask

    task automatic wr(input logic [8:0] a, input int n, input logic do_stop);
        logic [7:0] d;
        send_addr(DEV, straps, a[8], 1'b0, 1'b1);
        m.xfer(a[7:0], 8, 1'b1, rx, ack);
        check({8'h00, ack}, 9'h000);
        lat = a;
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            m.xfer(d, 8, 1'b1, rx, ack);
            check({8'h00, ack}, {8'h00, wp});
            if (!wp) begin
                mem[lat] = d;
                lat = next_addr(lat);
            end
        end
        if (do_stop) m.stop_cond();
    endtask

    task automatic rd(input logic pg, input int n);
        logic [8:0] a;
        send_addr(DEV, straps, pg, 1'b1, 1'b1);
        for (int k = 0; k < n; k++) begin
            a = {pg, lat[7:0]};
            m.xfer(8'hFF, 8, (k == n - 1), rx, ack);
            check({1'b0, rx}, {1'b0, mem[a]});
            check({8'h00, sda_out}, 9'h000);
            lat = next_addr(a);
        end
        m.stop_cond();
    endtask

    initial begin
        straps = 2'($urandom(32'h3D43));
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        repeat (5) @(negedge mclk);
        check({8'h00, sda_oe}, 9'h000);
        repeat (3) begin
            // Words stay low in the page so a burst never crosses into the other page.
            p_word = 9'($urandom) & 9'h17F;
            wr(p_word, 3, 1'b0);
            wr(p_word, 0, 1'b0);
            rd(p_word[8], 3);
        end
        wr(9'h1FE, 3, 1'b1);
        wr(9'h1FE, 0, 1'b0);
        rd(1'b1, 2);
        rd(1'b0, 1);
        for (int k = 1; k < 4; k++) begin
            send_addr(DEV, straps ^ 2'(k), 1'b0, 1'b0, 1'b0);
            m.stop_cond();
        end
        send_addr(DEV ^ 4'h8, straps, 1'b0, 1'b0, 1'b0);
        m.stop_cond();
        @(negedge mclk) wp = 1'b1;
        wr(p_word, 1, 1'b1);
        @(negedge mclk) wp = 1'b0;
        rd(p_word[8], 1);
        for (int k = 0; k < 2; k++) begin
            wr(p_word, 0, 1'b0);
            m.xfer(8'($urandom), 4, 1'b1, rx, ack);
            if (k == 0) m.stop_cond();
            rd(p_word[8], 1);
        end
        final_report();
    end

    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        final_report();
    end
endmodule // serial_nv_memory_two_wire_slave_bench

/* tb/two_wire_master.sv */
// Behavioural two-wire bus master that drives the memory's serial clock and data wire.
`timescale 1ns/1ps

module two_wire_master (
    output logic serial_clk,
    output logic sda_drive,
    input wire logic sda_wire
);
    // The clock rests high after a stop and only this model moves it.
    initial begin
        serial_clk = 1'b1;
        sda_drive = 1'b1;
    end

    // Data falls with the clock high; every frame, the first after reset too, opens so.
    task automatic start_cond();
        sda_drive = 1'b1;
        #15 serial_clk = 1'b1;
        #30 sda_drive = 1'b0;
        #30 serial_clk = 1'b0;
        #15;
    endtask

    // Issued only while this model owns the data wire, never inside read data.
    task automatic stop_cond();
        sda_drive = 1'b0;
        #15 serial_clk = 1'b1;
        #30 sda_drive = 1'b1;
        #30;
    endtask

    // Data changes only with the clock low; a high level releases the wire to the pull-up.
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic ack_in,
        output logic [7:0] rx, output logic ack_seen);
        rx = 8'h00;
        ack_seen = 1'b1;
        for (int i = 7; i > 7 - nbits; i--) begin
            sda_drive = tx[i];
            #15 serial_clk = 1'b1;
            rx[i] = sda_wire;
            #15 serial_clk = 1'b0;
            #15;
        end
        if (nbits == 8) begin
            sda_drive = ack_in;
            #15 serial_clk = 1'b1;
            ack_seen = sda_wire;
            #15 serial_clk = 1'b0;
            #15;
        end
    endtask
endmodule // two_wire_master
